/* rtl/dual_timer_map.svh */
// register offsets, field positions and reset values of the dual timer
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH
// byte offsets on the register bus
`define OFS_PRESCALE   8'h00
`define OFS_FIRST_CNT  8'h04
`define OFS_SECOND_CNT 8'h08
`define OFS_RELOAD_A   8'h0C
`define OFS_RELOAD_B   8'h10
`define OFS_CONTROL    8'h14
`define OFS_IRQ        8'h18
// interrupt register field positions
`define IRQ_EN_LSB     0
`define IRQ_PEND_LSB   4
`define IRQ_SRC_N      4
// reset values
`define RST_PRESCALE   5'h00
`define RST_COUNT      16'h0000
`define RST_CONTROL    14'h0000
`define RST_IRQ        4'h0
`endif

/* rtl/dual_timer_pkg.sv */
// types of the dual timer
package dual_timer_pkg;
  // operating mode, code 0 is mode 1
  typedef enum logic [1:0] {
    MODE_PWM     = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_DUAL    = 2'h2,
    MODE_RSVD    = 2'h3
  } mode_e;
  // counter clock source selector
  typedef enum logic [2:0] {
    SRC_NONE   = 3'h0,
    SRC_PRESC  = 3'h1,
    SRC_EXT    = 3'h2,
    SRC_PULSE  = 3'h3,
    SRC_SLOW   = 3'h4
  } clk_src_e;
  // control register layout, msb first
  typedef struct packed {
    logic     pin_a_output_level;
    logic     preset_b;
    logic     preset_a;
    logic     pin_b_neg;
    logic     pin_a_neg;
    logic     pin_a_enable;
    clk_src_e src2;
    clk_src_e src1;
    mode_e    mode;
  } ctrl_s;
endpackage

/* rtl/dual_timer.sv */
// dual 16-bit timer with prescaler, capture, pwm and wishbone registers
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_map.svh"
module dual_timer #(
  parameter int COUNT_W = 16,
  parameter int PRESC_W = 5
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // timer pins
  input  wire logic        pin_a_in,
  output logic             pin_a_out,
  output logic             pin_a_oe_out,
  input  wire logic        pin_b_in,
  input  wire logic        slow_clk_in,
  // system interrupts
  output logic             timer_irq1_out,
  output logic             timer_irq2_out
);
  import dual_timer_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (COUNT_W < 2 || COUNT_W > 16 || PRESC_W < 1 || PRESC_W > 8) begin : g_bad_param
    $error("dual_timer: unsupported COUNT_W or PRESC_W");
  end

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [COUNT_W-1:0] ONES = {COUNT_W{1'b1}};
  localparam logic [COUNT_W-1:0] ZERO = {COUNT_W{1'b0}};
  logic [PRESC_W-1:0] presc_div_reg;
  logic [PRESC_W-1:0] presc_cnt_reg;
  logic               presc_tick;
  logic [COUNT_W-1:0] cnt1_reg;
  logic [COUNT_W-1:0] cnt2_reg;
  logic [COUNT_W-1:0] rca_reg;
  logic [COUNT_W-1:0] rcb_reg;
  logic [COUNT_W-1:0] reload1;
  ctrl_s              ctrl_reg;
  ctrl_s              ctrl_next;
  logic [3:0]         irq_en_reg;
  logic [3:0]         pend_reg;
  logic [3:0]         pend_set;
  logic [3:0]         pend_clr;
  logic               use_b_reg;
  logic               ack_reg;
  logic [31:0]        rdata;
  logic [31:0]        wmerge;
  logic               bus_req;
  logic               wr_div, wr_cnt1, wr_cnt2, wr_rca, wr_rcb, wr_ctrl, wr_irq;
  logic [2:0]         sync1_reg;
  logic [2:0]         sync2_reg;
  logic [2:0]         sync3_reg;
  logic               edge_a, edge_b, level_b_ok, slow_tick;
  logic               tick1, tick2, uf1, uf2, cap_a, cap_b, preset1, toggle_a;
  logic               is_pwm, is_cap, restart;

  // ****************************************
  // register bus
  // ****************************************
  // apply byte enables to write data
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // a request is taken in its first cycle, ack follows one cycle later
  assign bus_req = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wb_ack_out = ack_reg;

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_in)
      `OFS_PRESCALE:   rdata[PRESC_W-1:0] = presc_div_reg;
      `OFS_FIRST_CNT:  rdata[COUNT_W-1:0] = cnt1_reg;
      `OFS_SECOND_CNT: rdata[COUNT_W-1:0] = cnt2_reg;
      `OFS_RELOAD_A:   rdata[COUNT_W-1:0] = rca_reg;
      `OFS_RELOAD_B:   rdata[COUNT_W-1:0] = rcb_reg;
      `OFS_CONTROL:    rdata[$bits(ctrl_s)-1:0] = ctrl_reg;
      `OFS_IRQ:        rdata[7:0] = {pend_reg, irq_en_reg};
      default:         rdata = 32'h0000_0000;
    endcase
  end

  // write strobes per register
  always_comb begin
    wmerge  = merge_lanes(rdata, wb_dat_in, wb_sel_in);
    wr_div  = bus_req & wb_we_in & (wb_adr_in == `OFS_PRESCALE);
    wr_cnt1 = bus_req & wb_we_in & (wb_adr_in == `OFS_FIRST_CNT);
    wr_cnt2 = bus_req & wb_we_in & (wb_adr_in == `OFS_SECOND_CNT);
    wr_rca  = bus_req & wb_we_in & (wb_adr_in == `OFS_RELOAD_A);
    wr_rcb  = bus_req & wb_we_in & (wb_adr_in == `OFS_RELOAD_B);
    wr_ctrl = bus_req & wb_we_in & (wb_adr_in == `OFS_CONTROL);
    wr_irq  = bus_req & wb_we_in & (wb_adr_in == `OFS_IRQ);
  end

  // ack pulse and registered read data
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ack_reg    <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        wb_dat_out <= rdata;
      end
    end
  end

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  // slow clock, pin b, pin a through two flops plus a history flop
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge mclk_in) begin
      if (srst_in) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
        sync3_reg[g] <= 1'b0;
      end else begin
        sync1_reg[g] <= (g == 0) ? pin_a_in : (g == 1) ? pin_b_in : slow_clk_in;
        sync2_reg[g] <= sync1_reg[g];
        sync3_reg[g] <= sync2_reg[g];
      end
    end
  end

  // selected-polarity edges of pins a and b, selected-polarity level of pin b, rising edge of the slow clock
  always_comb begin
    edge_a = ctrl_reg.pin_a_neg ? (sync3_reg[0] & ~sync2_reg[0])
                                : (~sync3_reg[0] & sync2_reg[0]);
    edge_b = ctrl_reg.pin_b_neg ? (sync3_reg[1] & ~sync2_reg[1])
                                : (~sync3_reg[1] & sync2_reg[1]);
    level_b_ok = ctrl_reg.pin_b_neg ? ~sync2_reg[1] : sync2_reg[1];
    slow_tick  = ~sync3_reg[2] & sync2_reg[2]; // no clock, no edge seen
  end

  // ****************************************
  // prescaler
  // ****************************************
  // divisor register, software access only
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      presc_div_reg <= PRESC_W'(`RST_PRESCALE);
    end else if (wr_div) begin
      presc_div_reg <= wmerge[PRESC_W-1:0];
    end
  end

  // hidden down counter, tick when it reaches zero
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      presc_cnt_reg <= PRESC_W'(`RST_PRESCALE);
    end else if (presc_cnt_reg == '0) begin
      presc_cnt_reg <= presc_div_reg;
    end else begin
      presc_cnt_reg <= presc_cnt_reg - 1'b1;
    end
  end
  assign presc_tick = (presc_cnt_reg == '0);

  // ****************************************
  // clock source selectors
  // ****************************************
  function automatic logic pick_tick(input clk_src_e src, input logic presc,
                                     input logic ext, input logic lvl,
                                     input logic slow);
    case (src)
      SRC_PRESC: return presc;
      SRC_EXT:   return ext;
      SRC_PULSE: return presc & lvl;
      SRC_SLOW:  return slow;
      default:   return 1'b0;
    endcase
  endfunction

  // per-counter ticks; capture mode keeps pin b away from counter 1
  always_comb begin
    is_pwm = (ctrl_reg.mode == MODE_PWM);
    is_cap = (ctrl_reg.mode == MODE_CAPTURE);
    tick1  = pick_tick(ctrl_reg.src1, presc_tick, edge_b, level_b_ok, slow_tick);
    if (is_cap && (ctrl_reg.src1 == SRC_EXT || ctrl_reg.src1 == SRC_PULSE)) begin
      tick1 = 1'b0;
    end
    tick2 = pick_tick(ctrl_reg.src2, presc_tick, edge_b, level_b_ok, slow_tick);
  end

  // ****************************************
  // counter 1 and capture registers
  // ****************************************
  // events of the first counter
  always_comb begin
    cap_a    = is_cap & edge_a;
    cap_b    = is_cap & edge_b;
    preset1  = (cap_a & ctrl_reg.preset_a) | (cap_b & ctrl_reg.preset_b);
    uf1      = tick1 & (cnt1_reg == ZERO) & ~wr_cnt1 & ~preset1;
    toggle_a = uf1 & ~is_cap & ctrl_reg.pin_a_enable;
    restart  = wr_ctrl & ((wmerge[1:0] != ctrl_reg.mode) | (wmerge[4:2] != ctrl_reg.src1));
    if (is_pwm) begin
      reload1 = use_b_reg ? rcb_reg : rca_reg;
    end else if (is_cap) begin
      reload1 = ONES;
    end else begin
      reload1 = rca_reg;
    end
  end

  // first counter: software load, capture preset, then counting
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt1_reg <= COUNT_W'(`RST_COUNT);
    end else if (wr_cnt1) begin
      cnt1_reg <= wmerge[COUNT_W-1:0];
    end else if (preset1) begin
      cnt1_reg <= ONES;
    end else if (uf1) begin
      cnt1_reg <= reload1;
    end else if (tick1) begin
      cnt1_reg <= cnt1_reg - 1'b1;
    end
  end

  // alternate reload selector, back to a on reset or restart
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      use_b_reg <= 1'b0;
    end else if (restart) begin
      use_b_reg <= 1'b0;
    end else if (uf1 && is_pwm) begin
      use_b_reg <= ~use_b_reg;
    end
  end

  // reload/capture a, capture wins over software
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rca_reg <= COUNT_W'(`RST_COUNT);
    end else if (cap_a) begin
      rca_reg <= cnt1_reg;
    end else if (wr_rca) begin
      rca_reg <= wmerge[COUNT_W-1:0];
    end
  end

  // reload/capture b, capture wins over software
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rcb_reg <= COUNT_W'(`RST_COUNT);
    end else if (cap_b) begin
      rcb_reg <= cnt1_reg;
    end else if (wr_rcb) begin
      rcb_reg <= wmerge[COUNT_W-1:0];
    end
  end

  // ****************************************
  // counter 2
  // ****************************************
  assign uf2 = tick2 & (cnt2_reg == ZERO) & ~wr_cnt2;

  // second counter wraps in modes 1/2, reloads from b otherwise
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt2_reg <= COUNT_W'(`RST_COUNT);
    end else if (wr_cnt2) begin
      cnt2_reg <= wmerge[COUNT_W-1:0];
    end else if (uf2) begin
      cnt2_reg <= (is_pwm | is_cap) ? ONES : rcb_reg;
    end else if (tick2) begin
      cnt2_reg <= cnt2_reg - 1'b1;
    end
  end

  // ****************************************
  // control, pin a and interrupts
  // ****************************************
  // control register, level bit toggled by hardware
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = ctrl_s'(wmerge[$bits(ctrl_s)-1:0]);
    end else if (toggle_a) begin
      ctrl_next.pin_a_output_level = ~ctrl_reg.pin_a_output_level;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_reg <= ctrl_s'(`RST_CONTROL);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // pin a mirrors the level bit, driven when pin_a_enable is set, except in capture mode
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pin_a_out    <= 1'b0;
      pin_a_oe_out <= 1'b0;
    end else begin
      pin_a_out    <= ctrl_next.pin_a_output_level;
      pin_a_oe_out <= ctrl_next.pin_a_enable & (ctrl_next.mode != MODE_CAPTURE);
    end
  end

  // pending sources a..d
  always_comb begin
    pend_set[0] = (uf1 & ~is_cap & (~is_pwm | ~use_b_reg)) | cap_a;
    pend_set[1] = (uf1 & is_pwm & use_b_reg) | cap_b;
    pend_set[2] = uf1 & is_cap;
    pend_set[3] = uf2;
    pend_clr    = wr_irq ? wmerge[`IRQ_PEND_LSB +: `IRQ_SRC_N] : 4'h0;
  end

  // enables and sticky pending, write one clears, set wins
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      irq_en_reg <= `RST_IRQ;
      pend_reg   <= `RST_IRQ;
    end else begin
      if (wr_irq) begin
        irq_en_reg <= wmerge[`IRQ_EN_LSB +: `IRQ_SRC_N];
      end
      pend_reg <= (pend_reg & ~pend_clr) | pend_set;
    end
  end

  // system interrupt requests
  assign timer_irq1_out = |(pend_reg[2:0] & irq_en_reg[2:0]);
  assign timer_irq2_out = pend_reg[3] & irq_en_reg[3];

  // ****************************************
  // assertions
  // ****************************************
  chk_presc_full_rate: assert property (@(posedge mclk_in) disable iff (srst_in)
    (presc_div_reg == '0 && $past(presc_div_reg) == '0 && $past(presc_cnt_reg) == '0)
      |-> presc_tick)
    else $error("prescaler not ticking at full rate");
  chk_presc_reset: assert property (@(posedge mclk_in)
    srst_in |=> (presc_div_reg == '0 && presc_cnt_reg == '0))
    else $error("prescaler not cleared by reset");
  chk_dual_reload: assert property (@(posedge mclk_in) disable iff (srst_in)
    (uf1 && ctrl_reg.mode == MODE_DUAL) |=> cnt1_reg == $past(rca_reg))
    else $error("mode 3 reload not from a");
  chk_pwm_alternate: assert property (@(posedge mclk_in) disable iff (srst_in)
    (uf1 && is_pwm) |=> cnt1_reg == ($past(use_b_reg) ? $past(rcb_reg) : $past(rca_reg)))
    else $error("pwm reload source wrong");
  chk_pwm_toggle: assert property (@(posedge mclk_in) disable iff (srst_in)
    (uf1 && is_pwm && ctrl_reg.pin_a_enable && !wr_ctrl)
      |=> pin_a_out != $past(pin_a_out))
    else $error("pin a not toggled on underflow");
  chk_pend_sticky: assert property (@(posedge mclk_in) disable iff (srst_in)
    (pend_reg[0] && !pend_clr[0]) |=> pend_reg[0])
    else $error("pending flag lost");
  chk_capture_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    cap_a |=> rca_reg == $past(cnt1_reg))
    else $error("capture a missed");
  chk_capture_preset: assert property (@(posedge mclk_in) disable iff (srst_in)
    (cap_b && ctrl_reg.preset_b && !wr_cnt1) |=> (cnt1_reg == ONES && pend_reg[1]))
    else $error("preset after capture missing");
  chk_cap_src_stop: assert property (@(posedge mclk_in) disable iff (srst_in)
    (is_cap && ctrl_reg.src1 == SRC_EXT && !wr_cnt1 && !preset1)
      |=> cnt1_reg == $past(cnt1_reg))
    else $error("counter 1 ran on pin b in capture mode");
  chk_irq1_gate: assert property (@(posedge mclk_in) disable iff (srst_in)
    (pend_set[0] && irq_en_reg[0] && !wr_irq) |=> timer_irq1_out)
    else $error("irq1 not raised by enabled pending a");
  chk_second_uf: assert property (@(posedge mclk_in) disable iff (srst_in)
    (uf2 && (is_pwm || is_cap)) |=> (pend_reg[3] && cnt2_reg == ONES))
    else $error("second underflow not flagged");
endmodule
`default_nettype wire

/* tb/pin_model.sv */
// pin side model: drives timer pins a and b and the slow clock
`timescale 1ns/10ps
`default_nettype none
module pin_model (
  // clock
  input  wire logic mclk_in,
  // driven pins
  output logic      pin_a_out,
  output logic      pin_b_out,
  output logic      slow_clk_out
);
  // pins start low, slow clock parked low
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
    slow_clk_out = 1'b0;
  end
  // level on pin a for n clocks, two at least
  task automatic hold_a(input logic lvl, input int n);
    @(posedge mclk_in) pin_a_out <= lvl;
    repeat ((n < 2 ? 2 : n) - 1) @(posedge mclk_in);
  endtask
  // level on pin b for n clocks, two at least
  task automatic hold_b(input logic lvl, input int n);
    @(posedge mclk_in) pin_b_out <= lvl;
    repeat ((n < 2 ? 2 : n) - 1) @(posedge mclk_in);
  endtask
  // n slow periods of eight clocks, then parked
  task automatic slow(input int n);
    repeat (2 * n) begin
      @(posedge mclk_in) slow_clk_out <= ~slow_clk_out;
      repeat (3) @(posedge mclk_in);
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the dual timer
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_map.svh"
module tb;
  import dual_timer_pkg::*;
  // design and model signals
  logic        mclk_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [7:0]  wb_adr_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic        wb_ack_out, pin_a_out, pin_a_oe_out, pa_drv, pin_b_in;
  logic        slow_clk_in, timer_irq1_out, timer_irq2_out, pa_q;
  int          n_fail, check_count, cyc_n;
  int          tq[$];
  // ****************
  // design and pins
  // ****************
  dual_timer i_dut (
    .mclk_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in (4'hf),
    .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .pin_a_in  (pin_a_oe_out ? pin_a_out : pa_drv),
    .pin_a_out, .pin_a_oe_out, .pin_b_in, .slow_clk_in,
    .timer_irq1_out, .timer_irq2_out
  );
  pin_model i_pins (
    .mclk_in,
    .pin_a_out    (pa_drv),
    .pin_b_out    (pin_b_in),
    .slow_clk_out (slow_clk_in)
  );
  // 5 ns clock
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // cycle stamps of pin a changes
  always @(negedge mclk_in) begin
    cyc_n <= cyc_n + 1;
    pa_q <= pin_a_out;
    if (pin_a_out !== pa_q) tq.push_back(cyc_n);
  end
  // verdict and end of run
  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // one classic wishbone cycle, bounded wait for ack
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    // ack and read data sampled at the rising edge, release right after it
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 40);
    if (wb_ack_out !== 1'b1) begin
      n_fail++;
      print_verdict();
    end else begin
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  // read and compare
  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    rd(a, q);
    chk(q === e, m);
  endtask
  // control word: flags [13:8], sources, mode
  task automatic cfg(input mode_e m, input clk_src_e s1, input clk_src_e s2,
                     input logic [5:0] fl);
    wr(`OFS_CONTROL, {18'h0_0000, fl, s2, s1, m});
  endtask
  // reset values, divisor width, unmapped place
  task automatic s_reset();
    rdx(`OFS_PRESCALE, 32'h0000_0000, "divisor reset");
    rdx(`OFS_IRQ, 32'h0000_0000, "irq reset");
    wr(`OFS_PRESCALE, 32'h0000_00FF);
    rdx(`OFS_PRESCALE, 32'h0000_001F, "divisor width");
    wr(8'h40, 32'h0000_1234);
    rdx(8'h40, 32'h0000_0000, "unmapped");
  endtask
  // counter rate over 64 clocks for three divisors
  task automatic s_presc();
    int dv[3] = '{0, 3, 31};
    logic [31:0] c0, c1;
    wr(`OFS_SECOND_CNT, 32'h0000_0100);
    cfg(MODE_DUAL, SRC_PRESC, SRC_NONE, 6'h00);
    foreach (dv[i]) begin
      wr(`OFS_PRESCALE, 32'(dv[i]));
      wr(`OFS_FIRST_CNT, 32'h0000_1000);
      repeat (40) @(posedge mclk_in);
      rd(`OFS_FIRST_CNT, c0);
      repeat (61) @(posedge mclk_in);
      rd(`OFS_FIRST_CNT, c1);
      chk(c0 - c1 === 32'(64 / (dv[i] + 1)), "prescaled rate");
    end
    rdx(`OFS_SECOND_CNT, 32'h0000_0100, "stopped counter");
  endtask
  // alternate reloads shape pin a, pending a and b
  task automatic s_pwm();
    logic [31:0] q;
    wr(`OFS_PRESCALE, 32'h0000_0000);
    wr(`OFS_RELOAD_A, 32'h0000_0004);
    wr(`OFS_RELOAD_B, 32'h0000_0009);
    wr(`OFS_FIRST_CNT, 32'h0000_0000);
    wr(`OFS_IRQ, 32'h0000_0001);
    cfg(MODE_PWM, SRC_NONE, SRC_NONE, 6'h21);
    repeat (3) @(posedge mclk_in);
    chk(pin_a_out === 1'b1 && pin_a_oe_out === 1'b1, "start level");
    tq.delete();
    cfg(MODE_PWM, SRC_PRESC, SRC_NONE, 6'h21);
    repeat (40) @(posedge mclk_in);
    cfg(MODE_PWM, SRC_NONE, SRC_NONE, 6'h01);
    chk(tq.size() > 3 && tq[1] - tq[0] == 5 && tq[2] - tq[1] == 10, "pwm");
    rd(`OFS_IRQ, q);
    chk(q[5:4] === 2'b11 && timer_irq1_out === 1'b1, "reload pend");
    wr(`OFS_IRQ, 32'h0000_0031);
    rdx(`OFS_IRQ, 32'h0000_0001, "pend clear");
    chk(timer_irq1_out === 1'b0, "irq one off");
  endtask
  // captures, stopped first counter, pin b events on counter two
  task automatic s_cap();
    logic [31:0] q;
    wr(`OFS_IRQ, 32'h0000_0000);
    wr(`OFS_FIRST_CNT, 32'h0000_0500);
    wr(`OFS_SECOND_CNT, 32'h0000_0500);
    cfg(MODE_CAPTURE, SRC_EXT, SRC_EXT, 6'h00);
    repeat (3) begin
      i_pins.hold_b(1'b1, 3);
      i_pins.hold_b(1'b0, 3);
    end
    repeat (4) @(posedge mclk_in);
    rdx(`OFS_FIRST_CNT, 32'h0000_0500, "stopped");
    rdx(`OFS_SECOND_CNT, 32'h0000_04FD, "b events");
    rdx(`OFS_RELOAD_B, 32'h0000_0500, "capture b");
    rdx(`OFS_IRQ, 32'h0000_0020, "b pending");
    wr(`OFS_IRQ, 32'h0000_00F0);
    wr(`OFS_FIRST_CNT, 32'h0000_8000);
    cfg(MODE_CAPTURE, SRC_PRESC, SRC_NONE, 6'h16);
    i_pins.hold_a(1'b1, 4);
    rdx(`OFS_RELOAD_A, 32'h0000_0004, "rise ignored");
    i_pins.hold_a(1'b0, 4);
    i_pins.hold_b(1'b1, 4);
    i_pins.hold_b(1'b0, 8);
    rd(`OFS_RELOAD_A, q);
    chk(q < 32'h0000_8000 && q > 32'h0000_7F00, "capture a");
    rd(`OFS_RELOAD_B, q);
    chk(q < 32'h0000_8000 && q > 32'h0000_7F00, "capture b fall");
    rd(`OFS_FIRST_CNT, q);
    chk(q > 32'h0000_FF00, "preset");
    wr(`OFS_FIRST_CNT, 32'h0000_0003);
    repeat (10) @(posedge mclk_in);
    rd(`OFS_IRQ, q);
    chk(q[7:4] === 4'h7, "three pendings");
  endtask
  // pulse accumulate, slow clock, counter two underflow
  task automatic s_cnt2();
    logic [31:0] c0, c1;
    wr(`OFS_SECOND_CNT, 32'h0000_0100);
    cfg(MODE_PWM, SRC_NONE, SRC_PULSE, 6'h00);
    rd(`OFS_SECOND_CNT, c0);
    i_pins.hold_b(1'b1, 20);
    i_pins.hold_b(1'b0, 10);
    rd(`OFS_SECOND_CNT, c1);
    chk(c0 - c1 === 32'h0000_0014, "accumulate");
    cfg(MODE_PWM, SRC_NONE, SRC_SLOW, 6'h00);
    rd(`OFS_SECOND_CNT, c0);
    i_pins.slow(5);
    repeat (6) @(posedge mclk_in);
    rd(`OFS_SECOND_CNT, c1);
    chk(c0 - c1 === 32'h0000_0005, "slow count");
    wr(`OFS_IRQ, 32'h0000_00F8);
    wr(`OFS_SECOND_CNT, 32'h0000_0000);
    cfg(MODE_PWM, SRC_NONE, SRC_PRESC, 6'h00);
    repeat (10) @(posedge mclk_in);
    rd(`OFS_SECOND_CNT, c0);
    chk(c0 > 32'h0000_FF00 && timer_irq2_out === 1'b1, "wrap");
    rdx(`OFS_IRQ, 32'h0000_0088, "d pending");
    wr(`OFS_RELOAD_B, 32'h0000_0050);
    wr(`OFS_RELOAD_A, 32'h0000_0040);
    cfg(MODE_DUAL, SRC_PRESC, SRC_PRESC, 6'h00);
    wr(`OFS_SECOND_CNT, 32'h0000_0000);
    wr(`OFS_FIRST_CNT, 32'h0000_0000);
    repeat (20) @(posedge mclk_in);
    rd(`OFS_SECOND_CNT, c0);
    chk(c0 <= 32'h0000_0050 && c0 > 32'h0000_0030, "reload b");
    rd(`OFS_FIRST_CNT, c1);
    chk(c1 <= 32'h0000_0040 && c1 > 32'h0000_0020, "reload a");
  endtask
  // reset, then the scenarios in turn
  initial begin
    srst_in = 1'b1;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = 8'h00;
    wb_dat_in = 32'h0000_0000;
    pa_q = 1'b0;
    cyc_n = 0;
    n_fail = 0;
    check_count = 0;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    s_reset();
    s_presc();
    s_pwm();
    s_cap();
    s_cnt2();
    print_verdict();
  end
endmodule
`default_nettype wire
